/* common/fcpi_consts.svh */
`ifndef FCPI_CONSTS_SVH
`define FCPI_CONSTS_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define FCPI_A_CTRL 8'h00
`define FCPI_A_STAT 8'h04
`define FCPI_A_ISTAT 8'h08
`define FCPI_A_IMASK 8'h0C
`define FCPI_A_SHIFT 8'h10
`define FCPI_A_GDIR 8'h14
`define FCPI_A_GOUT 8'h18
`define FCPI_A_GIN 8'h1C
`define FCPI_A_SDIO 8'h20
`define FCPI_A_SDIN 8'h24
`define FCPI_A_CDIV 8'h28
`define FCPI_RESP_OK 2'h0
`define FCPI_RESP_ERR 2'h2
// ----------------------------------------
// timing
// ----------------------------------------
`define FCPI_CLK_MHZ 100
`define FCPI_DEB_US 1000
`define FCPI_DEB_W 17
`define FCPI_CDIV_RST 8'h7C
`define FCPI_BIT_LAST 3'h7
// ----------------------------------------
// pin indices, pull patterns and interrupt bit indices
// ----------------------------------------
`define FCPI_GP_DET 0
`define FCPI_GP_WP 1
`define FCPI_GP_INS 2
`define FCPI_GP_DET2 3
`define FCPI_GP_WP2 4
`define FCPI_PIN_CMD 8
`define FCPI_PU_SD 9'h1FF
`define FCPI_PD_SER 9'h118
`define FCPI_PD_PAR 9'h1FB
`define FCPI_PU_GP 5'h1D
`define FCPI_PU_S2 10'h2FF
`define FCPI_INT_DET 0
`define FCPI_INT_SH 3
`endif

/* common/fcpi_pkg.sv */
package fcpi_pkg;
	typedef struct packed {
		logic shift_rx;
		logic sd_slot2;
		logic gpio_en;
		logic [1:0] bus_state;
		logic par_mode;
		logic stick_sel;
	} fcpi_ctrl_t;
	typedef enum logic [1:0] {SH_IDLE, SH_LOW, SH_HIGH} fcpi_sh_t;
endpackage : fcpi_pkg

/* verif/fcpi_card_model.sv */
`timescale 1ns/100ps

// ----------------------------------------
// card side of slot 1 pins
// ----------------------------------------
module fcpi_card_model (
	input wire logic aclk,
	input wire logic sclk,
	input wire logic send,
	input wire logic [7:0] tx_byte,
	input wire logic [8:0] host_o,
	input wire logic [8:0] host_oe,
	input wire logic [8:0] pu,
	input wire logic [8:0] pd,
	output logic [8:0] line_i
);
	logic [8:0] last_ff;
	logic [3:0] cnt_ff;
	logic sclk_ff;
	logic drv;
	logic tx_bit;
	assign drv = send && (cnt_ff < 4'h8);
	assign tx_bit = tx_byte[3'h7 - cnt_ff[2:0]];
	always_ff @(posedge aclk)
	begin
		sclk_ff <= sclk;
		last_ff <= line_i;
		if (!send)
			cnt_ff <= 4'h0;
		else if (sclk_ff && !sclk)
			cnt_ff <= cnt_ff + 4'h1;
	end
	always_comb
	begin
		for (int k = 0; k < 9; k++)
		begin
			if (host_oe[k])
				line_i[k] = host_o[k];
			else if (k == 8 && drv)
				line_i[k] = tx_bit;
			else if (pu[k])
				line_i[k] = 1'b1;
			else if (pd[k])
				line_i[k] = 1'b0;
			else
				line_i[k] = ~last_ff[k];
		end
	end
endmodule : fcpi_card_model

/* verif/fcpi_top_tb.sv */
`timescale 1ns/100ps
`include "fcpi_consts.svh"

module fcpi_top_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rd_d, g;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq, clk_o, cmd_o, cmd_oe;
	logic [1:0] bresp, rresp, rd_r;
	logic [31:0] rdata;
	logic [7:0] d_o, d_oe, tx_got, rx_b = 8'h00;
	logic [8:0] pu, pd, line_i;
	logic [4:0] gp_i, gp_o, gp_oe, gp_pu, sw = 5'h1F;
	logic [9:0] s2_i, s2_o, s2_oe, s2_pu;
	logic send = 1'b0;
	logic prev;
	int seed = 44;
	int n_errors = 0;
	int comparisons = 0;
	int tmo = 0;
	int n;

	always #5 aclk = ~aclk;
	assign gp_i = (gp_oe & gp_o) | (~gp_oe & sw);
	assign s2_i = (s2_oe & s2_o) | (~s2_oe & (s2_pu | ~s2_o));

	fcpi_top #(.DEB_CYC(8)) DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .card_clock_out(clk_o),
		.card_command_line_i(line_i[8]), .card_command_line_o(cmd_o),
		.card_command_line_oe(cmd_oe), .card_data_lines_i(line_i[7:0]),
		.card_data_lines_o(d_o), .card_data_lines_oe(d_oe), .card_pull_up_en(pu),
		.card_pull_dn_en(pd), .gp_pin_i(gp_i), .gp_pin_o(gp_o), .gp_pin_oe(gp_oe),
		.gp_pull_up_en(gp_pu), .slot2_lines_i(s2_i), .slot2_lines_o(s2_o),
		.slot2_lines_oe(s2_oe), .slot2_pull_up_en(s2_pu), .irq(irq));

	fcpi_card_model card (.aclk(aclk), .sclk(gp_o[1]), .send(send), .tx_byte(rx_b),
		.host_o({cmd_o, d_o}), .host_oe({cmd_oe, d_oe}), .pu(pu), .pd(pd), .line_i(line_i));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [8:0] exp_pd(input logic par);
		int pin_of[8] = '{8, 5, 4, 3, 0, 1, 7, 6};
		logic [8:0] m = 9'h000;
		for (int d = 0; d < 8; d++)
			if (par || d == 0 || d == 2 || d == 3)
				m[pin_of[d]] = 1'b1;
		return m;
	endfunction : exp_pd

	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		chk(bresp, er);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd_d = rdata;
		rd_r = rresp;
	endtask : rd

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk({rd_r, rd_d}, {2'h0, exp});
	endtask : rchk

	task automatic wait_irq;
		n = 0;
		while (irq !== 1'b1 && n < 600)
		begin
			@(posedge aclk);
			n++;
		end
		if (n == 600)
			n_errors++;
	endtask : wait_irq

	task close_out;
		if (n_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	always @(posedge aclk)
	begin
		tmo++;
		if (tmo == 20000)
		begin
			n_errors++;
			close_out;
		end
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial
	begin
		cyc(20);
		chk({pu, pd}, {9'h1FF, 9'h000});
		chk({gp_pu, s2_pu, irq}, {5'h1D, 10'h2FF, 1'b0});
		aresetn <= 1'b1;
		cyc(20);
		rchk(`FCPI_A_STAT, 32'h16);
		rchk(`FCPI_A_CDIV, 32'h7C);
		rd(8'h2C);
		chk({rd_r, rd_d}, {2'h2, 32'h0});
		wr(8'h2C, 32'h1, 2'h2);
		wr(`FCPI_A_IMASK, 32'h1, 2'h0);
		chk(irq, 1'b0);
		sw <= 5'h1A;
		cyc(30);
		rchk(`FCPI_A_STAT, 32'h13);
		rchk(`FCPI_A_ISTAT, 32'h3);
		chk(irq, 1'b1);
		wr(`FCPI_A_ISTAT, 32'h3, 2'h0);
		cyc(2);
		chk(irq, 1'b0);
		g = $random(seed);
		wr(`FCPI_A_SDIO, {14'h0, 2'h2, 8'hFF, g[7:0]}, 2'h0);
		cyc(2);
		chk({cmd_oe, cmd_o, d_oe, d_o}, {2'h2, 8'hFF, g[7:0]});
		wr(`FCPI_A_SDIO, 32'h0, 2'h0);
		cyc(4);
		rchk(`FCPI_A_SDIN, 32'h1FF);
		wr(`FCPI_A_CTRL, 32'h20, 2'h0);
		wr(`FCPI_A_SDIO, {16'h3FF, g[15:8]}, 2'h0);
		cyc(2);
		chk({s2_oe[9:0], s2_o[7:0]}, {10'h3FF, g[15:8]});
		for (int bs = 0; bs < 4; bs++)
		begin
			wr(`FCPI_A_CTRL, 32'h1 | (bs << 2), 2'h0);
			cyc(2);
			chk({clk_o, d_oe}, {bs[0], 8'h00});
		end
		wr(`FCPI_A_CTRL, 32'h3, 2'h0);
		cyc(2);
		chk({pu, pd}, {9'h000, exp_pd(1'b1)});
		wr(`FCPI_A_CTRL, 32'h1, 2'h0);
		cyc(2);
		chk(pd, exp_pd(1'b0));
		wr(`FCPI_A_CDIV, 32'h7, 2'h0);
		wr(`FCPI_A_IMASK, 32'h8, 2'h0);
		g = $random(seed);
		wr(`FCPI_A_SHIFT, {24'h0, g[7:0]}, 2'h0);
		n = 0;
		prev = gp_o[1];
		while (n < 8 && tmo < 19000)
		begin
			@(posedge aclk);
			if (gp_o[1] && !prev)
			begin
				tx_got = {tx_got[6:0], cmd_o};
				n++;
			end
			prev = gp_o[1];
		end
		chk(tx_got, g[7:0]);
		wait_irq;
		rchk(`FCPI_A_ISTAT, 32'h8);
		wr(`FCPI_A_ISTAT, 32'h8, 2'h0);
		cyc(2);
		chk(irq, 1'b0);
		wr(`FCPI_A_CTRL, 32'h41, 2'h0);
		g = $random(seed);
		rx_b <= g[7:0];
		send <= 1'b1;
		wr(`FCPI_A_SHIFT, 32'h0, 2'h0);
		wait_irq;
		rchk(`FCPI_A_SHIFT, {24'h0, rx_b});
		send <= 1'b0;
		wr(`FCPI_A_CTRL, 32'h10, 2'h0);
		wr(`FCPI_A_GDIR, 32'h7FFF, 2'h0);
		g = $random(seed);
		wr(`FCPI_A_GOUT, g, 2'h0);
		cyc(2);
		chk({gp_oe, s2_oe, gp_o, s2_o}, {15'h7FFF, g[14:0]});
		chk({gp_pu, s2_pu}, 15'h0);
		wr(`FCPI_A_GDIR, 32'h7BFF, 2'h0);
		cyc(6);
		sw <= 5'h1B;
		cyc(6);
		rchk(`FCPI_A_ISTAT, 32'h18);
		close_out;
	end
endmodule : fcpi_top_tb

/* verilog/fcpi_top.sv */
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
`include "fcpi_consts.svh"

module fcpi_top #(
	parameter int DEB_CYC = `FCPI_DEB_US * `FCPI_CLK_MHZ
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic card_clock_out,
	input wire logic card_command_line_i,
	output logic card_command_line_o,
	output logic card_command_line_oe,
	input wire logic [7:0] card_data_lines_i,
	output logic [7:0] card_data_lines_o,
	output logic [7:0] card_data_lines_oe,
	output logic [8:0] card_pull_up_en,
	output logic [8:0] card_pull_dn_en,
	input wire logic [4:0] gp_pin_i,
	output logic [4:0] gp_pin_o,
	output logic [4:0] gp_pin_oe,
	output logic [4:0] gp_pull_up_en,
	input wire logic [9:0] slot2_lines_i,
	output logic [9:0] slot2_lines_o,
	output logic [9:0] slot2_lines_oe,
	output logic [9:0] slot2_pull_up_en,
	output logic irq
);
	fcpi_pkg::fcpi_ctrl_t ctrl_ff;
	fcpi_pkg::fcpi_sh_t st_ff;
	logic [4:0] imask_ff, istat_ff, deb, chg, ev;
	logic [14:0] gdir_ff, gout_ff, gin_q_ff, gin_s;
	logic [17:0] sdio_ff;
	logic [7:0] cdiv_ff, cnt_ff, sh_ff, waddr_ff;
	logic [31:0] wdata_ff, wm;
	logic [3:0] wstrb_ff;
	logic [23:0] sy1_ff, sy2_ff;
	logic [2:0] bit_ff;
	logic [5:0] stat;
	logic aw_got_ff, w_got_ff, nxt_aw_got, nxt_w_got, nxt_rvalid;
	logic wr_do, tick, card_clock_out_ff, sclk_ff, busy, done, start, gedge;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic fcpi_map(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= `FCPI_A_CDIV);
	endfunction : fcpi_map

	function automatic logic [31:0] fcpi_rd(input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0;
		case (a)
			`FCPI_A_CTRL: r[6:0] = ctrl_ff;
			`FCPI_A_STAT: r[5:0] = stat;
			`FCPI_A_ISTAT: r[4:0] = istat_ff;
			`FCPI_A_IMASK: r[4:0] = imask_ff;
			`FCPI_A_SHIFT: r[7:0] = sh_ff;
			`FCPI_A_GDIR: r[14:0] = gdir_ff;
			`FCPI_A_GOUT: r[14:0] = gout_ff;
			`FCPI_A_GIN: r[14:0] = gin_s;
			`FCPI_A_SDIO: r[17:0] = sdio_ff;
			`FCPI_A_SDIN: r[8:0] = sy2_ff[8:0];
			`FCPI_A_CDIV: r[7:0] = cdiv_ff;
			default: r = 32'h0;
		endcase
		return r;
	endfunction : fcpi_rd

	function automatic logic [31:0] fcpi_wmerge(
		input logic [31:0] o,
		input logic [31:0] d,
		input logic [3:0] s
	);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
		begin
			if (s[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		end
		return r;
	endfunction : fcpi_wmerge

	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	assign wr_do = aw_got_ff && w_got_ff && !s_axi_bvalid;
	assign nxt_aw_got = (aw_got_ff && !wr_do) || (s_axi_awvalid && s_axi_awready);
	assign nxt_w_got = (w_got_ff && !wr_do) || (s_axi_wvalid && s_axi_wready);
	assign nxt_rvalid = (s_axi_rvalid && !s_axi_rready) || (s_axi_arvalid && s_axi_arready);
	// merge in a process so reads of the registers inside the function refresh it
	always_comb
	begin
		wm = fcpi_wmerge(fcpi_rd(waddr_ff), wdata_ff, wstrb_ff);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `FCPI_RESP_OK;
			waddr_ff <= 8'h0;
			wdata_ff <= 32'h0;
			wstrb_ff <= 4'h0;
		end
		else
		begin
			aw_got_ff <= nxt_aw_got;
			w_got_ff <= nxt_w_got;
			s_axi_awready <= !nxt_aw_got;
			s_axi_wready <= !nxt_w_got;
			if (s_axi_awvalid && s_axi_awready)
				waddr_ff <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_do)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= fcpi_map(waddr_ff) ? `FCPI_RESP_OK : `FCPI_RESP_ERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `FCPI_RESP_OK;
		end
		else
		begin
			s_axi_rvalid <= nxt_rvalid;
			s_axi_arready <= !nxt_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rdata <= fcpi_rd(s_axi_araddr);
				s_axi_rresp <= fcpi_map(s_axi_araddr) ? `FCPI_RESP_OK : `FCPI_RESP_ERR;
			end
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_ff <= '0;
			imask_ff <= 5'h0;
			gdir_ff <= 15'h0;
			gout_ff <= 15'h0;
			sdio_ff <= 18'h0;
			cdiv_ff <= `FCPI_CDIV_RST;
		end
		else if (wr_do)
		begin
			case (waddr_ff)
				`FCPI_A_CTRL: ctrl_ff <= fcpi_pkg::fcpi_ctrl_t'(wm[6:0]);
				`FCPI_A_IMASK: imask_ff <= wm[4:0];
				`FCPI_A_GDIR: gdir_ff <= wm[14:0];
				`FCPI_A_GOUT: gout_ff <= wm[14:0];
				`FCPI_A_SDIO: sdio_ff <= wm[17:0];
				`FCPI_A_CDIV: cdiv_ff <= wm[7:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// input sync and debounce
	// ----------------------------------------
	// two-stage sync
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sy1_ff <= 24'h0;
			sy2_ff <= 24'h0;
			gin_q_ff <= 15'h0;
		end
		else
		begin
			sy1_ff <= {slot2_lines_i, gp_pin_i, card_command_line_i, card_data_lines_i};
			sy2_ff <= sy1_ff;
			gin_q_ff <= gin_s;
		end
	end
	assign gin_s = {sy2_ff[13:9], sy2_ff[23:14]};

	for (genvar g = 0; g < 5; g++)
	begin : g_deb
		logic [`FCPI_DEB_W-1:0] dcnt_ff;
		logic deb_ff;
		assign chg[g] = (dcnt_ff == `FCPI_DEB_W'(DEB_CYC - 1)) && (sy2_ff[9+g] != deb_ff);
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				dcnt_ff <= '0;
				deb_ff <= 1'b1;
			end
			else if (sy2_ff[9+g] == deb_ff || chg[g])
			begin
				dcnt_ff <= '0;
				deb_ff <= sy2_ff[9+g];
			end
			else
				dcnt_ff <= dcnt_ff + `FCPI_DEB_W'(1);
		end
		assign deb[g] = deb_ff;
	end

	assign stat = {busy, deb[`FCPI_GP_WP2], !deb[`FCPI_GP_DET2], deb[`FCPI_GP_INS],
		deb[`FCPI_GP_WP], !deb[`FCPI_GP_DET]};

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	// edge interrupt inputs
	assign gedge = ctrl_ff.gpio_en && |(gin_s & ~gin_q_ff & ~gdir_ff);
	assign ev = {gedge, done, chg[`FCPI_GP_DET2] && !ctrl_ff.gpio_en,
		chg[`FCPI_GP_INS] && !ctrl_ff.gpio_en, chg[`FCPI_GP_DET] && !ctrl_ff.gpio_en};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			istat_ff <= 5'h0;
			irq <= 1'b0;
		end
		else
		begin
			if (wr_do && waddr_ff == `FCPI_A_ISTAT && wstrb_ff[0])
				istat_ff <= (istat_ff & ~wdata_ff[4:0]) | ev;
			else
				istat_ff <= istat_ff | ev;
			irq <= |(istat_ff & imask_ff);
		end
	end

	// ----------------------------------------
	// clock divider and stick shifter
	// ----------------------------------------
	assign tick = (cnt_ff == cdiv_ff);
	assign busy = (st_ff != fcpi_pkg::SH_IDLE);
	assign done = (st_ff == fcpi_pkg::SH_HIGH) && tick && (bit_ff == 3'h0);
	assign start = wr_do && waddr_ff == `FCPI_A_SHIFT && !busy && ctrl_ff.stick_sel;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_ff <= 8'h0;
			card_clock_out_ff <= 1'b0;
		end
		else
		begin
			cnt_ff <= tick ? 8'h0 : cnt_ff + 8'h1;
			if (tick)
				card_clock_out_ff <= !card_clock_out_ff;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_ff <= fcpi_pkg::SH_IDLE;
			sh_ff <= 8'h0;
			bit_ff <= 3'h0;
			sclk_ff <= 1'b0;
		end
		else
		begin
			unique case (st_ff)
				fcpi_pkg::SH_IDLE:
				begin
					sclk_ff <= 1'b0;
					if (start)
					begin
						sh_ff <= wm[7:0];
						bit_ff <= `FCPI_BIT_LAST;
						st_ff <= fcpi_pkg::SH_LOW;
					end
				end
				fcpi_pkg::SH_LOW:
				begin
					if (tick)
					begin
						sclk_ff <= 1'b1;
						st_ff <= fcpi_pkg::SH_HIGH;
						if (ctrl_ff.shift_rx)
							sh_ff <= {sh_ff[6:0], sy2_ff[`FCPI_PIN_CMD]};
					end
				end
				fcpi_pkg::SH_HIGH:
				begin
					if (tick)
					begin
						sclk_ff <= 1'b0;
						if (!ctrl_ff.shift_rx)
							sh_ff <= {sh_ff[6:0], 1'b0};
						bit_ff <= bit_ff - 3'h1;
						st_ff <= (bit_ff == 3'h0) ? fcpi_pkg::SH_IDLE : fcpi_pkg::SH_LOW;
					end
				end
				default: st_ff <= fcpi_pkg::SH_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// slot 1 pin mux
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			card_clock_out <= 1'b0;
			card_command_line_o <= 1'b0;
			card_command_line_oe <= 1'b0;
			card_data_lines_o <= 8'h0;
			card_data_lines_oe <= 8'h0;
			card_pull_up_en <= `FCPI_PU_SD;
			card_pull_dn_en <= 9'h0;
		end
		else if (ctrl_ff.stick_sel)
		begin
			card_clock_out <= ctrl_ff.bus_state[0];
			card_command_line_o <= sh_ff[7];
			card_command_line_oe <= busy && !ctrl_ff.shift_rx;
			card_data_lines_o <= 8'h0;
			card_data_lines_oe <= 8'h0;
			card_pull_up_en <= 9'h0;
			card_pull_dn_en <= ctrl_ff.par_mode ? `FCPI_PD_PAR : `FCPI_PD_SER;
		end
		else
		begin
			card_clock_out <= card_clock_out_ff && !ctrl_ff.sd_slot2;
			card_command_line_o <= sdio_ff[16];
			card_command_line_oe <= sdio_ff[17] && !ctrl_ff.sd_slot2;
			card_data_lines_o <= sdio_ff[7:0];
			card_data_lines_oe <= ctrl_ff.sd_slot2 ? 8'h0 : sdio_ff[15:8];
			card_pull_up_en <= `FCPI_PU_SD;
			card_pull_dn_en <= 9'h0;
		end
	end

	// ----------------------------------------
	// general pins and slot 2
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			gp_pin_o <= 5'h0;
			gp_pin_oe <= 5'h0;
			gp_pull_up_en <= `FCPI_PU_GP;
			slot2_lines_o <= 10'h0;
			slot2_lines_oe <= 10'h0;
			slot2_pull_up_en <= `FCPI_PU_S2;
		end
		else if (ctrl_ff.gpio_en)
		begin
			gp_pin_o <= gout_ff[14:10];
			gp_pin_oe <= gdir_ff[14:10];
			gp_pull_up_en <= 5'h0;
			slot2_lines_o <= gout_ff[9:0];
			slot2_lines_oe <= gdir_ff[9:0];
			slot2_pull_up_en <= 10'h0;
		end
		else
		begin
			gp_pin_o <= {3'h0, sclk_ff, 1'b0};
			gp_pin_oe <= {3'h0, ctrl_ff.stick_sel, 1'b0};
			gp_pull_up_en <= `FCPI_PU_GP;
			slot2_lines_o <= {sdio_ff[16], card_clock_out_ff && ctrl_ff.sd_slot2, sdio_ff[7:0]};
			slot2_lines_oe <= {sdio_ff[17] && ctrl_ff.sd_slot2, 1'b1,
				ctrl_ff.sd_slot2 ? sdio_ff[15:8] : 8'h0};
			slot2_pull_up_en <= `FCPI_PU_S2;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_pd_ser;
		@(posedge aclk) disable iff (!aresetn)
		ctrl_ff.stick_sel && !ctrl_ff.par_mode |=> card_pull_dn_en == `FCPI_PD_SER;
	endproperty
	a_pd_ser: assert property (p_pd_ser) else $error("serial pull-downs wrong");
	property p_pd_par;
		@(posedge aclk) disable iff (!aresetn)
		ctrl_ff.stick_sel && ctrl_ff.par_mode |=> card_pull_dn_en == `FCPI_PD_PAR;
	endproperty
	a_pd_par: assert property (p_pd_par) else $error("parallel pull-downs wrong");
	property p_pu_sd;
		@(posedge aclk) disable iff (!aresetn)
		!ctrl_ff.stick_sel |=> card_pull_up_en == `FCPI_PU_SD && card_pull_dn_en == 9'h0;
	endproperty
	a_pu_sd: assert property (p_pu_sd) else $error("sd pull-ups wrong");
	property p_msb;
		@(posedge aclk) disable iff (!aresetn)
		start && !ctrl_ff.shift_rx |=> ##1 card_command_line_o == $past(wm[7], 2);
	endproperty
	a_msb: assert property (p_msb) else $error("first bit not msb");
	property p_sclk;
		@(posedge aclk) disable iff (!aresetn)
		ctrl_ff.stick_sel && !ctrl_ff.gpio_en |=> gp_pin_oe[`FCPI_GP_WP];
	endproperty
	a_sclk: assert property (p_sclk) else $error("stick clock not driven");
	property p_sdclk;
		@(posedge aclk) disable iff (!aresetn)
		(!ctrl_ff.stick_sel && !ctrl_ff.sd_slot2 && tick) ##1 (!ctrl_ff.stick_sel && !ctrl_ff.sd_slot2)
		|=> card_clock_out != $past(card_clock_out);
	endproperty
	a_sdclk: assert property (p_sdclk) else $error("sd clock stuck");
	property p_bs;
		@(posedge aclk) disable iff (!aresetn)
		ctrl_ff.stick_sel |=> card_clock_out == $past(ctrl_ff.bus_state[0]);
	endproperty
	a_bs: assert property (p_bs) else $error("bus state pin wrong");
	property p_det_irq;
		@(posedge aclk) disable iff (!aresetn)
		chg[`FCPI_GP_DET] && !ctrl_ff.gpio_en && imask_ff[`FCPI_INT_DET]
		|=> istat_ff[`FCPI_INT_DET] ##1 irq;
	endproperty
	a_det_irq: assert property (p_det_irq) else $error("detect event lost");
	property p_gpio;
		@(posedge aclk) disable iff (!aresetn)
		ctrl_ff.gpio_en |=> slot2_lines_oe == $past(gdir_ff[9:0]);
	endproperty
	a_gpio: assert property (p_gpio) else $error("gpio direction wrong");
	property p_det_in;
		@(posedge aclk) disable iff (!aresetn)
		!ctrl_ff.gpio_en |=> !gp_pin_oe[`FCPI_GP_DET] && !gp_pin_oe[`FCPI_GP_INS];
	endproperty
	a_det_in: assert property (p_det_in) else $error("detect pin driven");
	c_tx: cover property (@(posedge aclk) disable iff (!aresetn) done && !ctrl_ff.shift_rx);
	c_rx: cover property (@(posedge aclk) disable iff (!aresetn) done && ctrl_ff.shift_rx);
	c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
	c_gp: cover property (@(posedge aclk) disable iff (!aresetn) gedge);
endmodule : fcpi_top
